// ---- inc/lobm_defines.svh ----
`ifndef LOBM_DEFINES_SVH
`define LOBM_DEFINES_SVH

// register offsets, enhanced map
`define LB_A_MAP  8'h01
`define LB_A_IE   8'h20
`define LB_A_ST   8'h21
`define LB_A_CFG  8'h22
`define LB_A_SFP0 8'h23
`define LB_A_SFP1 8'h24
`define LB_A_SFP2 8'h25
`define LB_A_SFS0 8'h26
`define LB_A_SFS1 8'h27
`define LB_A_SFD0 8'h28
`define LB_A_SFD1 8'h29
`define LB_A_SFC0 8'h2a
`define LB_A_SFC1 8'h2b
`define LB_A_SDP0 8'h2c
`define LB_A_SDP1 8'h2d
`define LB_A_SDP2 8'h2e
`define LB_A_SDS0 8'h2f
`define LB_A_SDS1 8'h30
`define LB_A_SDD0 8'h31
`define LB_A_SDD1 8'h32
`define LB_A_SDC0 8'h33
`define LB_A_SDC1 8'h34
`define LB_A_K1   8'h35
`define LB_A_K2   8'h36
`define LB_A_Z1   8'h37

// config bit positions
`define LB_B_Z1F  7
`define LB_B_SFEN 6
`define LB_B_SFS  5
`define LB_B_SFC  4
`define LB_B_SDEN 3
`define LB_B_SDS  2
`define LB_B_SDC  1

// flag positions inside the 5-bit flag field (status bits 7..3)
`define LB_F_PROT_BYTE_FAIL_ALARM 4
`define LB_F_APS  3
`define LB_F_Z1   2
`define LB_F_SF   1
`define LB_F_SD   0

// reset values and counts
`define LB_RST_BYTE  8'h00
`define LB_SAT_OFF   12'hfff
`define LB_NSUB      8
`define LB_CLR_LONG  7'd64
`define LB_Z1_RUN    2'h2

`endif

// ---- inc/lobm_pkg.sv ----
package lobm_pkg;

    typedef struct packed {
        logic        en;
        logic        smode;
        logic        cmode;
        logic [23:0] period;
        logic [11:0] dth;
        logic [11:0] cth;
        logic [11:0] sth;
    } lobm_error_rate_monitor_cfg_t;

    typedef struct packed {
        logic        frame;
        logic [11:0] b2_err;
        logic [7:0]  k1;
        logic [7:0]  k2;
        logic [3:0]  z1;
        logic        prot_byte_fail_alarm;
    } lobm_oh_t;

    typedef struct packed {
        logic [23:0]      frame_cnt;
        logic [15:0]      sub;
        logic [7:0][15:0] ring;
        logic [2:0]       idx;
        logic [6:0]       clr_run;
        logic             alarm;
        logic             evt;
    } lobm_error_rate_monitor_st_t;

    typedef struct packed {
        logic        map_sel;
        logic [7:0]  ie;
        logic [4:0]  flags;
        logic [7:0]  cfg;
        logic [23:0] sf_per;
        logic [11:0] sf_sth;
        logic [11:0] sf_dth;
        logic [11:0] sf_cth;
        logic [23:0] sd_per;
        logic [11:0] sd_sth;
        logic [11:0] sd_dth;
        logic [11:0] sd_cth;
        logic [7:0]  k1;
        logic [7:0]  k2;
        logic [3:0]  z1;
        logic [3:0]  z1_cand;
        logic [1:0]  z1_run;
        logic        prot_byte_fail_alarm_d;
        logic [7:0]  rd_data;
        logic        irq;
    } lobm_top_st_t;

endpackage

// ---- rtl/lobm_top.sv ----
//Contract
// RULE1: new K1/K2 code sets the APS change flag; status read clears it
// RULE2: protection byte alarm declare or removal sets its flag; status read clears it
// RULE3: degrade alarm clears over declare window, or eight times it when selected
// RULE4: fail alarm clears over declare window, or eight times it when selected
// RULE5: degrade saturation caps errors per frame, or per subtotal period
// RULE6: fail saturation caps errors per frame, or per subtotal period
// RULE7: degrade enable runs accumulation; off resets to declaration monitoring
// RULE8: fail enable runs accumulation; off resets to declaration monitoring
// RULE9: software programs periods and thresholds before setting a monitor enable
// RULE10: sync filter needs three equal nibbles; otherwise each nibble written directly
// RULE11: fail period counts frames per subtotal; window sums eight subtotals
// RULE12: config register at 22H only in enhanced map, with documented bit layout
// RULE13: fail period in three read-write bytes 23H to 25H, reset zero
// RULE14: fail alarm declares at sum >= declare threshold, clears below clear threshold
// RULE15: saturation threshold of all ones disables saturation
// RULE16: interrupt output high while any enabled flag is set
// RULE17: one error count per frame strobe advances the subtotal frame counter
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "lobm_defines.svh"

module lobm_error_rate_monitor
    import lobm_pkg::*;
(
    // clock and reset
    input  wire logic           core_clk,
    input  wire logic           rst,
    // settings and per-frame errors
    input  wire lobm_error_rate_monitor_cfg_t cfg,
    input  wire logic           frame_stb,
    input  wire logic [11:0]    err_cnt,
    // alarm state
    output logic                alarm,
    output logic                evt
);
    lobm_error_rate_monitor_st_t s_reg;
    lobm_error_rate_monitor_st_t s_next;
    logic [18:0]   sum_next;
    logic [16:0]   acc;
    logic [11:0]   e;
    logic          sat_on;
    logic          sub_end;
    logic [6:0]    need;

    always_comb
    begin
        s_next     = s_reg;
        s_next.evt = 1'b0;
        sum_next   = 19'h0;
        sat_on     = cfg.sth != `LB_SAT_OFF; // [RULE15]
        // per-frame cap in frame mode
        e = (!cfg.smode && sat_on && err_cnt > cfg.sth) ? cfg.sth : err_cnt; // [RULE5] [RULE6]
        acc = {1'b0, s_reg.sub} + {5'h00, e};
        if (acc[16])
            acc = 17'h0ffff;
        // per-subtotal cap in period mode
        if (cfg.smode && sat_on && acc > {5'h00, cfg.sth})
            acc = {5'h00, cfg.sth}; // [RULE5] [RULE6]
        // zero period holds the monitor: no subtotal ever closes
        sub_end = frame_stb && cfg.period != 24'h0
                  && (s_reg.frame_cnt + 24'h1) >= cfg.period; // [RULE11] [RULE17]
        need = cfg.cmode ? `LB_CLR_LONG : 7'd1; // [RULE3] [RULE4]
        if (!cfg.en)
        begin
            s_next = '0; // [RULE7] [RULE8]
        end
        else if (sub_end)
        begin
            s_next.ring[s_reg.idx] = acc[15:0];
            s_next.idx             = s_reg.idx + 3'h1;
            s_next.sub             = 16'h0;
            s_next.frame_cnt       = 24'h0;
            for (int i = 0; i < `LB_NSUB; i++)
                sum_next = sum_next + {3'h0, s_next.ring[i]}; // [RULE11]
            if (!s_reg.alarm)
            begin
                if (sum_next >= {7'h00, cfg.dth})
                begin
                    s_next.alarm   = 1'b1; // [RULE14]
                    s_next.evt     = 1'b1;
                    s_next.clr_run = 7'h0;
                end
            end
            else if (sum_next < {7'h00, cfg.cth})
            begin
                // long clearing mode needs eight whole windows below threshold
                if (s_reg.clr_run + 7'h1 >= need)
                begin
                    s_next.alarm   = 1'b0; // [RULE14] [RULE3] [RULE4]
                    s_next.evt     = 1'b1;
                    s_next.clr_run = 7'h0;
                end
                else
                    s_next.clr_run = s_reg.clr_run + 7'h1;
            end
            else
                s_next.clr_run = 7'h0;
        end
        else if (frame_stb)
        begin
            s_next.sub       = acc[15:0];
            s_next.frame_cnt = s_reg.frame_cnt + 24'h1; // [RULE17]
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign alarm = s_reg.alarm;
    assign evt   = s_reg.evt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_below;
        sub_end && cfg.en && s_reg.alarm && sum_next < {7'h00, cfg.cth};
    endsequence

    chk_off_idle: assert property ( // [RULE7] [RULE8]
        !cfg.en |=> !alarm && s_reg.sub == 16'h0 && s_reg.frame_cnt == 24'h0)
        else $error("disabled monitor kept state");
    chk_period_cap: assert property ( // [RULE5] [RULE6]
        cfg.en && cfg.smode && sat_on && frame_stb |=> s_reg.sub <= $past(cfg.sth))
        else $error("subtotal above saturation threshold");
    chk_frame_cap: assert property ( // [RULE5] [RULE6]
        cfg.en && !cfg.smode && sat_on && frame_stb && !sub_end
        |=> s_reg.sub <= 17'h0 + $past(s_reg.sub) + $past(cfg.sth))
        else $error("frame errors not capped");
    chk_declare_now: assert property ( // [RULE14] [RULE11]
        sub_end && cfg.en && !s_reg.alarm && sum_next >= {7'h00, cfg.dth}
        |=> alarm && evt)
        else $error("alarm not declared at threshold");
    chk_short_clear: assert property ( // [RULE3] [RULE4]
        (s_below ##0 !cfg.cmode) |=> !alarm && evt)
        else $error("short window clear missed");
    chk_long_clear: assert property ( // [RULE3] [RULE4]
        $fell(alarm) && $past(cfg.en) && $past(cfg.cmode)
        |-> $past(s_reg.clr_run) == `LB_CLR_LONG - 7'd1)
        else $error("long window clear too early");
endmodule

module lobm_top
    import lobm_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // overhead from the receive framer
    input  wire lobm_oh_t   oh_in,
    // alarms and interrupt
    output logic            sd_alarm,
    output logic            sf_alarm,
    output logic            irq
);
    lobm_top_st_t   s_reg;
    lobm_top_st_t   n;
    lobm_error_rate_monitor_cfg_t sd_cfg;
    lobm_error_rate_monitor_cfg_t sf_cfg;
    logic           sd_evt;
    logic           sf_evt;
    logic           enhanced_map_select;
    logic           rd_st;
    logic           aps_new;
    logic           prot_byte_fail_alarm_chg;
    logic           z1_wr;

    assign sd_cfg = '{en: s_reg.cfg[`LB_B_SDEN], smode: s_reg.cfg[`LB_B_SDS],
                      cmode: s_reg.cfg[`LB_B_SDC], period: s_reg.sd_per,
                      dth: s_reg.sd_dth, cth: s_reg.sd_cth, sth: s_reg.sd_sth};
    assign sf_cfg = '{en: s_reg.cfg[`LB_B_SFEN], smode: s_reg.cfg[`LB_B_SFS],
                      cmode: s_reg.cfg[`LB_B_SFC], period: s_reg.sf_per,
                      dth: s_reg.sf_dth, cth: s_reg.sf_cth, sth: s_reg.sf_sth};

    lobm_error_rate_monitor u_sd (
        .core_clk  (core_clk),
        .rst       (rst),
        .cfg       (sd_cfg),
        .frame_stb (oh_in.frame),
        .err_cnt   (oh_in.b2_err),
        .alarm     (sd_alarm),
        .evt       (sd_evt)
    );

    lobm_error_rate_monitor u_sf (
        .core_clk  (core_clk),
        .rst       (rst),
        .cfg       (sf_cfg),
        .frame_stb (oh_in.frame),
        .err_cnt   (oh_in.b2_err),
        .alarm     (sf_alarm),
        .evt       (sf_evt)
    );

    always_comb
    begin
        n        = s_reg;
        enhanced_map_select      = s_reg.map_sel;
        rd_st    = reg_rd && enhanced_map_select && reg_addr == `LB_A_ST;
        aps_new  = oh_in.frame && {oh_in.k1, oh_in.k2} != {s_reg.k1, s_reg.k2};
        prot_byte_fail_alarm_chg = oh_in.frame && oh_in.prot_byte_fail_alarm != s_reg.prot_byte_fail_alarm_d; // [RULE2]
        z1_wr    = 1'b0;
        // writes; the whole 20H..37H block is absent in the legacy map
        if (reg_wr)
        begin
            if (reg_addr == `LB_A_MAP)
                n.map_sel = reg_wdata[0];
            else if (!enhanced_map_select)
                n.map_sel = s_reg.map_sel;
            else if (reg_addr == `LB_A_IE)
                n.ie = reg_wdata;
            else if (reg_addr == `LB_A_ST)
                n.flags = s_reg.flags & ~reg_wdata[7:3];
            else if (reg_addr == `LB_A_CFG)
                n.cfg = {reg_wdata[7:1], 1'b0}; // [RULE12]
            else if (reg_addr == `LB_A_SFP0)
                n.sf_per[7:0] = reg_wdata; // [RULE13]
            else if (reg_addr == `LB_A_SFP1)
                n.sf_per[15:8] = reg_wdata; // [RULE13]
            else if (reg_addr == `LB_A_SFP2)
                n.sf_per[23:16] = reg_wdata; // [RULE13]
            else if (reg_addr == `LB_A_SFS0)
                n.sf_sth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SFS1)
                n.sf_sth[11:8] = reg_wdata[3:0];
            else if (reg_addr == `LB_A_SFD0)
                n.sf_dth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SFD1)
                n.sf_dth[11:8] = reg_wdata[3:0];
            else if (reg_addr == `LB_A_SFC0)
                n.sf_cth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SFC1)
                n.sf_cth[11:8] = reg_wdata[3:0];
            else if (reg_addr == `LB_A_SDP0)
                n.sd_per[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SDP1)
                n.sd_per[15:8] = reg_wdata;
            else if (reg_addr == `LB_A_SDP2)
                n.sd_per[23:16] = reg_wdata;
            else if (reg_addr == `LB_A_SDS0)
                n.sd_sth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SDS1)
                n.sd_sth[11:8] = reg_wdata[3:0];
            else if (reg_addr == `LB_A_SDD0)
                n.sd_dth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SDD1)
                n.sd_dth[11:8] = reg_wdata[3:0];
            else if (reg_addr == `LB_A_SDC0)
                n.sd_cth[7:0] = reg_wdata;
            else if (reg_addr == `LB_A_SDC1)
                n.sd_cth[11:8] = reg_wdata[3:0];
        end
        // overhead capture, once per frame
        if (aps_new)
        begin
            n.k1 = oh_in.k1; // [RULE1]
            n.k2 = oh_in.k2;
        end
        if (oh_in.frame)
        begin
            if (!s_reg.cfg[`LB_B_Z1F])
            begin
                n.z1      = oh_in.z1; // [RULE10]
                n.z1_cand = oh_in.z1;
                n.z1_run  = 2'h0;
                z1_wr     = oh_in.z1 != s_reg.z1;
            end
            else if (oh_in.z1 == s_reg.z1_cand)
            begin
                if (s_reg.z1_run != `LB_Z1_RUN)
                    n.z1_run = s_reg.z1_run + 2'h1;
                // third equal frame commits the nibble
                if (s_reg.z1_run + 2'h1 >= `LB_Z1_RUN && oh_in.z1 != s_reg.z1)
                begin
                    n.z1  = oh_in.z1; // [RULE10]
                    z1_wr = 1'b1;
                end
            end
            else
            begin
                n.z1_cand = oh_in.z1;
                n.z1_run  = 2'h0;
            end
        end
        // alarm level only means something in a frame cycle
        if (oh_in.frame)
            n.prot_byte_fail_alarm_d = oh_in.prot_byte_fail_alarm;
        // read clears, then new events; set beats clear in the same cycle
        if (rd_st)
            n.flags = 5'h00; // [RULE1] [RULE2]
        n.flags = n.flags | {prot_byte_fail_alarm_chg, aps_new, z1_wr, sf_evt, sd_evt}; // [RULE1] [RULE2]
        n.irq   = |(n.flags & n.ie[7:3]); // [RULE16]
        // read data, one cycle after the strobe
        n.rd_data = `LB_RST_BYTE;
        if (!reg_rd)
            n.rd_data = `LB_RST_BYTE;
        else if (reg_addr == `LB_A_MAP)
            n.rd_data = {7'h00, s_reg.map_sel};
        else if (!enhanced_map_select)
            n.rd_data = `LB_RST_BYTE; // [RULE12]
        else if (reg_addr == `LB_A_IE)
            n.rd_data = s_reg.ie;
        else if (reg_addr == `LB_A_ST)
            n.rd_data = {s_reg.flags, sf_alarm, sd_alarm, 1'b0};
        else if (reg_addr == `LB_A_CFG)
            n.rd_data = s_reg.cfg; // [RULE12]
        else if (reg_addr == `LB_A_SFP0)
            n.rd_data = s_reg.sf_per[7:0]; // [RULE13]
        else if (reg_addr == `LB_A_SFP1)
            n.rd_data = s_reg.sf_per[15:8];
        else if (reg_addr == `LB_A_SFP2)
            n.rd_data = s_reg.sf_per[23:16];
        else if (reg_addr == `LB_A_SFS0)
            n.rd_data = s_reg.sf_sth[7:0];
        else if (reg_addr == `LB_A_SFS1)
            n.rd_data = {4'h0, s_reg.sf_sth[11:8]};
        else if (reg_addr == `LB_A_SFD0)
            n.rd_data = s_reg.sf_dth[7:0];
        else if (reg_addr == `LB_A_SFD1)
            n.rd_data = {4'h0, s_reg.sf_dth[11:8]};
        else if (reg_addr == `LB_A_SFC0)
            n.rd_data = s_reg.sf_cth[7:0];
        else if (reg_addr == `LB_A_SFC1)
            n.rd_data = {4'h0, s_reg.sf_cth[11:8]};
        else if (reg_addr == `LB_A_SDP0)
            n.rd_data = s_reg.sd_per[7:0];
        else if (reg_addr == `LB_A_SDP1)
            n.rd_data = s_reg.sd_per[15:8];
        else if (reg_addr == `LB_A_SDP2)
            n.rd_data = s_reg.sd_per[23:16];
        else if (reg_addr == `LB_A_SDS0)
            n.rd_data = s_reg.sd_sth[7:0];
        else if (reg_addr == `LB_A_SDS1)
            n.rd_data = {4'h0, s_reg.sd_sth[11:8]};
        else if (reg_addr == `LB_A_SDD0)
            n.rd_data = s_reg.sd_dth[7:0];
        else if (reg_addr == `LB_A_SDD1)
            n.rd_data = {4'h0, s_reg.sd_dth[11:8]};
        else if (reg_addr == `LB_A_SDC0)
            n.rd_data = s_reg.sd_cth[7:0];
        else if (reg_addr == `LB_A_SDC1)
            n.rd_data = {4'h0, s_reg.sd_cth[11:8]};
        else if (reg_addr == `LB_A_K1)
            n.rd_data = s_reg.k1;
        else if (reg_addr == `LB_A_K2)
            n.rd_data = s_reg.k2;
        else if (reg_addr == `LB_A_Z1)
            n.rd_data = {4'h0, s_reg.z1};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= n;
    end

    assign reg_rdata = s_reg.rd_data;
    assign irq       = s_reg.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_quiet_read;
        rd_st && !oh_in.frame && !prot_byte_fail_alarm_chg && !sd_evt && !sf_evt;
    endsequence

    chk_aps_set: assert property ( // [RULE1]
        aps_new |=> s_reg.flags[`LB_F_APS] && s_reg.k1 == $past(oh_in.k1))
        else $error("apsk change not flagged");
    chk_prot_byte_fail_alarm_set: assert property ( // [RULE2]
        oh_in.frame && oh_in.prot_byte_fail_alarm != s_reg.prot_byte_fail_alarm_d |=> s_reg.flags[`LB_F_PROT_BYTE_FAIL_ALARM])
        else $error("protection byte alarm change not flagged");
    chk_read_clear: assert property ( // [RULE1] [RULE2]
        s_quiet_read |=> s_reg.flags == 5'h00 && reg_rdata[7:3] == $past(s_reg.flags))
        else $error("status read did not return and clear");
    chk_z1_filter: assert property ( // [RULE10]
        $past(s_reg.cfg[`LB_B_Z1F]) && $changed(s_reg.z1)
        |-> $past(s_reg.z1_run) != 2'h0 && $past(oh_in.z1) == $past(s_reg.z1_cand))
        else $error("sync nibble taken before three frames");
    chk_z1_direct: assert property ( // [RULE10]
        !s_reg.cfg[`LB_B_Z1F] && oh_in.frame |=> s_reg.z1 == $past(oh_in.z1))
        else $error("sync nibble not written directly");
    chk_irq_level: assert property ( // [RULE16]
        irq == |(s_reg.flags & s_reg.ie[7:3]))
        else $error("interrupt output wrong");
    chk_map_gate: assert property ( // [RULE12]
        reg_rd && !s_reg.map_sel && reg_addr == `LB_A_CFG |=> reg_rdata == 8'h00)
        else $error("config visible in legacy map");
    chk_period_rb: assert property ( // [RULE13]
        reg_wr && s_reg.map_sel && reg_addr == `LB_A_SFP2
        ##1 reg_rd && !reg_wr && reg_addr == `LB_A_SFP2
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("fail period byte readback wrong");
endmodule

// ---- verif/lobm_framer.sv ----
`timescale 1ns/1ps

module lobm_framer
    import lobm_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // overhead toward the monitor
    output lobm_oh_t  oh
);
    initial oh = '0;

    // idle cycles carry the inverse of the last frame so stale fields never look valid
    task automatic send(input int n, input logic [11:0] b2, input logic [7:0] k1,
                        input logic [3:0] z1, input logic prot_byte_fail_alarm);
        lobm_oh_t f;
        f = '{frame: 1'b1, b2_err: b2, k1: k1, k2: ~k1, z1: z1, prot_byte_fail_alarm: prot_byte_fail_alarm};
        repeat (n)
        begin
            @(posedge core_clk);
            oh <= f;
        end
        @(posedge core_clk);
        oh <= ~f;
    endtask
endmodule

// ---- verif/lobm_top_bench.sv ----
`timescale 1ns/1ps
`include "lobm_defines.svh"

module lobm_top_bench
    import lobm_pkg::*;
();
    logic        core_clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        rd_d = 1'b0;
    logic        sd_alarm;
    logic        sf_alarm;
    logic        irq;
    lobm_oh_t    oh;
    int          err_total;
    int          check_count;
    int          cyc;
    logic [31:0] seed;
    logic [7:0]  expq[$];
    logic [11:0] sth_t[4] = '{12'hfff, 12'h005, 12'h00b, 12'hfff};
    logic [3:0]  sm_t = 4'b1100;
    logic [3:0]  ex_t = 4'b1001;

    lobm_top uut (
        .core_clk (core_clk),
        .rst      (rst),
        .reg_addr (reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .reg_rdata(reg_rdata),
        .oh_in    (oh),
        .sd_alarm (sd_alarm),
        .sf_alarm (sf_alarm),
        .irq      (irq)
    );

    lobm_framer fr (
        .core_clk(core_clk),
        .oh      (oh)
    );

    always #4 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic al(input int m);
        return m ? sd_alarm : sf_alarm;
    endfunction

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        expq.push_back(d);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    // periods and thresholds go in first, the enable last
    task automatic set_mon(input int m, input logic [2:0] esc, input logic [11:0] sth);
        logic [7:0] b;
        b = m ? `LB_A_SDP0 : `LB_A_SFP0;
        wr(b, 8'h02);
        wr(b + 8'h01, 8'h00);
        wr(b + 8'h02, 8'h00);
        wr(b + 8'h03, sth[7:0]);
        wr(b + 8'h04, {4'h0, sth[11:8]});
        wr(b + 8'h05, 8'h0c);
        wr(b + 8'h06, 8'h00);
        wr(b + 8'h07, 8'h05);
        wr(b + 8'h08, 8'h00);
        wr(`LB_A_CFG, m ? {4'h0, esc, 1'b0} : {1'b0, esc, 4'h0});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            chk(reg_rdata, expq.pop_front(), "reg_rdata");
        cyc++;
        if (cyc == 10000)
        begin
            err_total++;
            wrap_up();
        end
    end

    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        seed = 32'hcf6ed4c3;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(`LB_A_CFG, 8'h00);
        wr(`LB_A_CFG, 8'hff);
        wr(`LB_A_MAP, 8'h01);
        rd(`LB_A_CFG, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            rd(`LB_A_SFP0 + 8'(i), 8'h00);
            wr_rd(`LB_A_SFP0 + 8'(i), seed[7:0]);
        end
        seed = xs(seed);
        wr(`LB_A_CFG, seed[7:0]);
        rd(`LB_A_CFG, seed[7:0] & 8'hfe);
        wr(`LB_A_CFG, 8'h00);
        rd(8'h40, 8'h00);
        wr(`LB_A_IE, 8'h40);
        fr.send(1, 12'h000, 8'h5a, 4'h0, 1'b0);
        #1 chk(irq, 1'b1, "irq");
        rd(`LB_A_K1, 8'h5a);
        rd(`LB_A_ST, 8'h40);
        rd(`LB_A_ST, 8'h00);
        #1 chk(irq, 1'b0, "irq");
        fr.send(1, 12'h000, 8'h5a, 4'h0, 1'b1);
        #1 chk(irq, 1'b0, "irq masked");
        rd(`LB_A_ST, 8'h80);
        fr.send(1, 12'h000, 8'h5a, 4'h0, 1'b0);
        rd(`LB_A_ST, 8'h80);
        wr(`LB_A_CFG, 8'h80);
        fr.send(2, 12'h000, 8'h5a, 4'h9, 1'b0);
        rd(`LB_A_Z1, 8'h00);
        fr.send(1, 12'h000, 8'h5a, 4'h9, 1'b0);
        rd(`LB_A_Z1, 8'h09);
        wr(`LB_A_CFG, 8'h00);
        fr.send(1, 12'h000, 8'h5a, 4'h3, 1'b0);
        rd(`LB_A_Z1, 8'h03);
        // each monitor: saturation table, then both clearing windows
        for (int m = 0; m < 2; m++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                wr(`LB_A_CFG, 8'h00);
                @(posedge core_clk);
                #1 chk(al(m), 1'b0, "alarm off");
                set_mon(m, {1'b1, sm_t[i], 1'b0}, sth_t[i]);
                fr.send(1, 12'h006, 8'h5a, 4'h3, 1'b0);
                #1 chk(al(m), 1'b0, "alarm half");
                fr.send(1, 12'h006, 8'h5a, 4'h3, 1'b0);
                #1 chk(al(m), ex_t[i], "alarm sat");
            end
            for (int c = 0; c < 2; c++)
            begin
                wr(`LB_A_CFG, 8'h00);
                set_mon(m, {2'b10, c[0]}, 12'hfff);
                fr.send(2, 12'h006, 8'h5a, 4'h3, 1'b0);
                #1 chk(al(m), 1'b1, "alarm set");
                fr.send(c ? 140 : 14, 12'h000, 8'h5a, 4'h3, 1'b0);
                #1 chk(al(m), 1'b1, "alarm hold");
                fr.send(2, 12'h000, 8'h5a, 4'h3, 1'b0);
                #1 chk(al(m), 1'b0, "alarm clear");
            end
        end
        repeat (3) @(posedge core_clk);
        wrap_up();
    end
endmodule
